/* File: smrc_defs.vh */
`ifndef SMRC_DEFS_VH
`define SMRC_DEFS_VH
// Parameter addresses, word index on the parameter port
`define SMRC_ADDR_AN1_USAGE   16'h091C
`define SMRC_ADDR_AN2_USAGE   16'h0926
`define SMRC_ADDR_PT_REF_CUR  16'h2008
`define SMRC_ADDR_OP_MODE     16'h3000
`define SMRC_ADDR_PT_INVERT   16'h3002
`define SMRC_ADDR_AN_OFFSET   16'h3004
`define SMRC_ADDR_AN_ZEROWIN  16'h3006
`define SMRC_ADDR_STATUS      16'h3008
// Reset values
`define SMRC_AN1_USAGE_RST    16'h0001
`define SMRC_AN2_USAGE_RST    16'h0000
`define SMRC_PT_REF_CUR_RST   16'h0000
// Ranges
`define SMRC_AN1_USAGE_MAX    16'h0004
`define SMRC_AN2_USAGE_MAX    16'h0005
`define SMRC_PT_REF_CUR_MAX   16'hB4DC
`define SMRC_AN_ZEROWIN_MAX   16'h7FFF
// Usage codes
`define SMRC_USE_NONE         3'h0
`define SMRC_USE_TGT_VEL      3'h1
`define SMRC_USE_TGT_TRQ      3'h2
`define SMRC_USE_VEL_LIM      3'h3
`define SMRC_USE_CUR_LIM      3'h4
// Operating modes
`define SMRC_MODE_TORQUE      2'h1
`define SMRC_MODE_VELOCITY    2'h2
// Drive states
`define SMRC_ST_RDY_ON        4'h4
`define SMRC_ST_SW_ON         4'h5
`define SMRC_ST_OP_EN         4'h6
// Pulse rate full scale, increments per second
`define SMRC_PT_FULL_RATE     32'd1600000
`define SMRC_CLK_HZ           32'd250000000
// 100 us count window: 160 increments at full rate
`define SMRC_PT_WIN_CYC       18'h061A8
`define SMRC_PT_WIN_INC       16'h00A0
`endif

/* File: smrc_servo_mode_ref.v */
`include "smrc_defs.vh"
module smrc_servo_mode_ref (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        parWrite,
  input  wire        parRead,
  input  wire [15:0] parAddr,
  input  wire [15:0] parWdata,
  output reg  [15:0] parRdata,
  output reg         parAck,
  output reg         parReject,
  input  wire        pulseTrainA,
  input  wire        pulseTrainB,
  input  wire [15:0] analogInOne,
  input  wire [15:0] analogInTwo,
  input  wire [5:0]  digitalIn,
  input  wire [3:0]  driveState,
  input  wire        velInWindow,
  input  wire        motorStandstill,
  input  wire        selectedError,
  input  wire        quickStop,
  input  wire        errorStop,
  output reg  [4:0]  digitalOut,
  output reg  [15:0] torqueRefCurrent,
  output reg         torqueRefNegative,
  output reg         velocityModeActive,
  output reg         powerStageEnable,
  output reg         faultResetReq,
  output reg         modeSwitchReq,
  output reg         velLimitReq,
  output reg         zeroClampReq,
  output reg         haltReq,
  output reg  [2:0]  analogOneUse,
  output reg  [2:0]  analogTwoUse,
  output reg  [15:0] analogOneTarget,
  output reg  [15:0] analogTwoTarget
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
reg [7:0] pinMeta_reg;
reg [7:0] pinSync_reg;
always @(posedge clk_sys or posedge sys_rst) begin
  if (sys_rst) begin
    pinMeta_reg <= 8'h00;
    pinSync_reg <= 8'h00;
  end else begin
    pinMeta_reg <= {pulseTrainA, pulseTrainB, digitalIn};
    pinSync_reg <= pinMeta_reg;
  end
end
wire       ptA  = pinSync_reg[7];
wire       ptB  = pinSync_reg[6];
wire [5:0] dIn  = pinSync_reg[5:0];

////////////////////////////////////////////////////////////////////////////////
// Parameters
reg [15:0] an1Use_reg;
reg [15:0] an2Use_reg;
reg [15:0] refCur_reg;
reg [1:0]  opMode_reg;
reg        ptInvert_reg;
reg [15:0] anOffset_reg;
reg [15:0] anZeroWin_reg;
reg        stageEn_reg;

function inRange;
  input [15:0] val;
  input [15:0] maxVal;
  begin
    inRange = (val <= maxVal);
  end
endfunction

wire wrAn1  = parWrite && parAddr == `SMRC_ADDR_AN1_USAGE;
wire wrAn2  = parWrite && parAddr == `SMRC_ADDR_AN2_USAGE;
wire wrCur  = parWrite && parAddr == `SMRC_ADDR_PT_REF_CUR;
wire wrMode = parWrite && parAddr == `SMRC_ADDR_OP_MODE;
wire wrInv  = parWrite && parAddr == `SMRC_ADDR_PT_INVERT;
wire wrOff  = parWrite && parAddr == `SMRC_ADDR_AN_OFFSET;
wire wrWin  = parWrite && parAddr == `SMRC_ADDR_AN_ZEROWIN;
wire okAn1  = !stageEn_reg && inRange(parWdata, `SMRC_AN1_USAGE_MAX);
wire okAn2  = !stageEn_reg && inRange(parWdata, `SMRC_AN2_USAGE_MAX);
wire okCur  = inRange(parWdata, `SMRC_PT_REF_CUR_MAX);
wire okMode = parWdata[15:2] == 14'h0000 && parWdata[1:0] != 2'h3;
wire okInv  = parWdata[15:1] == 15'h0000;
wire okWin  = inRange(parWdata, `SMRC_AN_ZEROWIN_MAX);
wire anyWr  = wrAn1 | wrAn2 | wrCur | wrMode | wrInv | wrOff | wrWin;
wire wrOk   = (wrAn1 & okAn1) | (wrAn2 & okAn2) | (wrCur & okCur)
            | (wrMode & okMode) | (wrInv & okInv) | wrOff | (wrWin & okWin);

always @(posedge clk_sys or posedge sys_rst) begin
  if (sys_rst) begin
    an1Use_reg    <= `SMRC_AN1_USAGE_RST;
    an2Use_reg    <= `SMRC_AN2_USAGE_RST;
    refCur_reg    <= `SMRC_PT_REF_CUR_RST;
    opMode_reg    <= `SMRC_MODE_VELOCITY;
    ptInvert_reg  <= 1'b0;
    anOffset_reg  <= 16'h0000;
    anZeroWin_reg <= 16'h0000;
  end else begin
    if (wrAn1 && okAn1)
      an1Use_reg <= parWdata;
    if (wrAn2 && okAn2)
      an2Use_reg <= parWdata;
    if (wrCur && okCur)
      refCur_reg <= parWdata;
    if (wrMode && okMode)
      opMode_reg <= parWdata[1:0];
    if (wrInv && okInv)
      ptInvert_reg <= parWdata[0];
    if (wrOff)
      anOffset_reg <= parWdata;
    if (wrWin && okWin)
      anZeroWin_reg <= parWdata;
  end
end

reg [15:0] rdMux;
always @* begin
  case (parAddr)
    `SMRC_ADDR_AN1_USAGE:  rdMux = an1Use_reg;
    `SMRC_ADDR_AN2_USAGE:  rdMux = an2Use_reg;
    `SMRC_ADDR_PT_REF_CUR: rdMux = refCur_reg;
    `SMRC_ADDR_OP_MODE:    rdMux = {14'h0000, opMode_reg};
    `SMRC_ADDR_PT_INVERT:  rdMux = {15'h0000, ptInvert_reg};
    `SMRC_ADDR_AN_OFFSET:  rdMux = anOffset_reg;
    `SMRC_ADDR_AN_ZEROWIN: rdMux = anZeroWin_reg;
    `SMRC_ADDR_STATUS:     rdMux = {driveState, 6'h00, velocityModeActive,
                                    stageEn_reg, 4'h0};
    default:               rdMux = 16'h0000;
  endcase
end

always @(posedge clk_sys or posedge sys_rst) begin
  if (sys_rst) begin
    parRdata  <= 16'h0000;
    parAck    <= 1'b0;
    parReject <= 1'b0;
  end else begin
    parRdata  <= parRead ? rdMux : 16'h0000;
    parAck    <= parRead | (parWrite & wrOk);
    parReject <= parWrite & ~(anyWr & wrOk);
  end
end

////////////////////////////////////////////////////////////////////////////////
// Digital input defaults; functions are routed by mode
always @(posedge clk_sys or posedge sys_rst) begin
  if (sys_rst) begin
    stageEn_reg      <= 1'b0;
    powerStageEnable <= 1'b0;
    faultResetReq    <= 1'b0;
    modeSwitchReq    <= 1'b0;
    velLimitReq      <= 1'b0;
    zeroClampReq     <= 1'b0;
    haltReq          <= 1'b0;
  end else begin
    stageEn_reg      <= dIn[0];
    powerStageEnable <= dIn[0];
    faultResetReq    <= dIn[1];
    modeSwitchReq    <= dIn[2];
    // Torque mode has no velocity limit or clamp function
    velLimitReq      <= dIn[3] && opMode_reg == `SMRC_MODE_VELOCITY;
    zeroClampReq     <= dIn[4] && opMode_reg == `SMRC_MODE_VELOCITY;
    haltReq          <= dIn[5];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Velocity mode sequencing
localparam [2:0] VM_IDLE = 3'b001;
localparam [2:0] VM_RUN  = 3'b010;
localparam [2:0] VM_STOP = 3'b100;
reg [2:0] vmState_reg;
reg [2:0] vmState_next;
reg       stagePrev_reg;
wire      stageRise = stageEn_reg & ~stagePrev_reg;
wire      stopCause = dIn[5] | quickStop | errorStop | ~stageEn_reg;

always @* begin
  case (vmState_reg)
    VM_IDLE:
      vmState_next = (stageRise && opMode_reg == `SMRC_MODE_VELOCITY)
                   ? VM_RUN : VM_IDLE;
    VM_RUN:
      vmState_next = stopCause ? VM_STOP : VM_RUN;
    VM_STOP:
      vmState_next = motorStandstill ? VM_IDLE : VM_STOP;
    default:
      vmState_next = VM_IDLE;
  endcase
end

always @(posedge clk_sys or posedge sys_rst) begin
  if (sys_rst) begin
    vmState_reg        <= VM_IDLE;
    stagePrev_reg      <= 1'b0;
    velocityModeActive <= 1'b0;
    analogOneUse       <= 3'h0;
    analogTwoUse       <= 3'h0;
  end else begin
    vmState_reg        <= vmState_next;
    stagePrev_reg      <= stageEn_reg;
    velocityModeActive <= vmState_next != VM_IDLE;
    if (stageRise) begin
      analogOneUse <= an1Use_reg[2:0];
      analogTwoUse <= an2Use_reg[2:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Digital output defaults
always @(posedge clk_sys or posedge sys_rst) begin
  if (sys_rst) begin
    digitalOut <= 5'h00;
  end else begin
    digitalOut[0] <= driveState == `SMRC_ST_RDY_ON
                  || driveState == `SMRC_ST_SW_ON
                  || driveState == `SMRC_ST_OP_EN;
    digitalOut[1] <= driveState == `SMRC_ST_OP_EN;
    // Velocity window only means something in velocity mode
    digitalOut[2] <= velInWindow
                  && opMode_reg == `SMRC_MODE_VELOCITY;
    digitalOut[3] <= motorStandstill;
    digitalOut[4] <= selectedError;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Pulse train torque reference: quadrature decode, count over 100 us window
reg [1:0]  abPrev_reg;
reg [17:0] winCnt_reg;
reg signed [12:0] incCnt_reg;
reg signed [12:0] incLast_reg;
wire       stepA = ptA ^ abPrev_reg[1];
wire       stepB = ptB ^ abPrev_reg[0];
wire       fwd   = stepA ? (ptA ^ ptB) : (ptA ~^ ptB);
wire       step  = stepA ^ stepB;
wire       winEnd = winCnt_reg == `SMRC_PT_WIN_CYC - 18'h00001;
wire [12:0] incMag = incLast_reg[12] ? -incLast_reg : incLast_reg;
// 160 increments per window equals full scale; short window keeps
// the update rate up at the cost of coarser resolution
wire [28:0] scaled = incMag[11:0] * refCur_reg / `SMRC_PT_WIN_INC;

always @(posedge clk_sys or posedge sys_rst) begin
  if (sys_rst) begin
    abPrev_reg        <= 2'b00;
    winCnt_reg        <= 18'h00000;
    incCnt_reg        <= 13'h0000;
    incLast_reg       <= 13'h0000;
    torqueRefCurrent  <= 16'h0000;
    torqueRefNegative <= 1'b0;
  end else begin
    abPrev_reg <= {ptA, ptB};
    if (winEnd) begin
      winCnt_reg  <= 18'h00000;
      incLast_reg <= incCnt_reg;
      // A step on the closing cycle opens the next window, never lost
      incCnt_reg  <= step ? (fwd ? 13'h0001 : 13'h1FFF) : 13'h0000;
    end else begin
      winCnt_reg <= winCnt_reg + 18'h00001;
      if (step)
        incCnt_reg <= fwd ? incCnt_reg + 13'h0001 : incCnt_reg - 13'h0001;
    end
    if (opMode_reg == `SMRC_MODE_TORQUE) begin
      torqueRefCurrent  <= (scaled > {13'h0000, refCur_reg})
                         ? refCur_reg : scaled[15:0];
      torqueRefNegative <= incLast_reg[12] ^ ptInvert_reg;
    end else begin
      torqueRefCurrent  <= 16'h0000;
      torqueRefNegative <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Analog target forming: offset then zero window
function [15:0] anForm;
  input [15:0] raw;
  input [15:0] off;
  input [15:0] win;
  reg signed [16:0] sum;
  reg [16:0] mag;
  begin
    sum = $signed({raw[15], raw}) + $signed({off[15], off});
    mag = sum[16] ? -sum : sum;
    if (mag <= {1'b0, win})
      anForm = 16'h0000;
    else if (sum > 17'sh07FFF)
      anForm = 16'h7FFF;
    else if (sum < -17'sh08000)
      anForm = 16'h8000;
    else
      anForm = sum[15:0];
  end
endfunction

always @(posedge clk_sys or posedge sys_rst) begin
  if (sys_rst) begin
    analogOneTarget <= 16'h0000;
    analogTwoTarget <= 16'h0000;
  end else begin
    analogOneTarget <= anForm(analogInOne, anOffset_reg, anZeroWin_reg);
    analogTwoTarget <= anForm(analogInTwo, anOffset_reg, anZeroWin_reg);
  end
end

endmodule

/* File: smrc_servo_mode_ref_asserts.sv */
module smrc_servo_mode_ref_asserts (
  input wire        clk_sys,
  input wire        sys_rst,
  input wire        parWrite,
  input wire        parRead,
  input wire        parAck,
  input wire        parReject,
  input wire [3:0]  driveState,
  input wire        motorStandstill,
  input wire        selectedError,
  input wire [4:0]  digitalOut,
  input wire [15:0] torqueRefCurrent,
  input wire        velocityModeActive
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  AST_WR_ANSWER: assert property (parWrite |=> parAck != parReject)
    else $error("write not answered by exactly one of ack or reject");
  AST_RD_ANSWER: assert property (parRead |=> parAck && !parReject)
    else $error("read not acknowledged");
  // Past values from inside reset are not trusted
  AST_NO_FAULT: assert property (!$past(sys_rst) |->
    digitalOut[0] == ($past(driveState) inside {4'h4, 4'h5, 4'h6}))
    else $error("no fault output wrong");
  AST_ACTIVE: assert property (!$past(sys_rst) |->
    digitalOut[1] == ($past(driveState) == 4'h6))
    else $error("active output wrong");
  AST_STANDSTILL: assert property (!$past(sys_rst) |->
    digitalOut[3] == $past(motorStandstill))
    else $error("standstill output wrong");
  AST_SEL_ERROR: assert property (!$past(sys_rst) |->
    digitalOut[4] == $past(selectedError))
    else $error("selected error output wrong");
  AST_TRQ_ZERO: assert property (velocityModeActive |->
    torqueRefCurrent == 16'h0000)
    else $error("torque reference outside torque mode");
  AST_RC_MAX: assert property (torqueRefCurrent <= 16'hB4DC)
    else $error("torque reference above range");
  AST_VEL_END: assert property ($fell(velocityModeActive) &&
    !$past(sys_rst) |-> $past(motorStandstill))
    else $error("velocity mode ended while moving");
  ////////////////////////////////////////////////////////////////////////////
  COV_REJECT: cover property (parReject);
  COV_VEL_START: cover property ($rose(velocityModeActive));
  COV_VEL_END: cover property ($fell(velocityModeActive));
endmodule

bind smrc_servo_mode_ref smrc_servo_mode_ref_asserts chk_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .parWrite(parWrite),
  .parRead(parRead), .parAck(parAck), .parReject(parReject),
  .driveState(driveState), .motorStandstill(motorStandstill),
  .selectedError(selectedError), .digitalOut(digitalOut),
  .torqueRefCurrent(torqueRefCurrent),
  .velocityModeActive(velocityModeActive)
);

/* File: smrc_ctrl_model.sv */
module smrc_ctrl_model (
  input  wire logic run,
  input  wire logic reverse,
  input  wire logic slow,
  output logic      pulseTrainA,
  output logic      pulseTrainB
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] phase = 2'h0;
  // Quadrature only; 625 ns per step is full scale, slow halves it
  always #(slow ? 1250 : 625) begin
    if (run) phase <= reverse ? phase - 2'h1 : phase + 2'h1;
  end
  // Gray sequence, A leads B when counting up
  assign pulseTrainA = phase[1] ^ phase[0];
  assign pulseTrainB = phase[1];
endmodule

/* File: tb_smrc_servo_mode_ref.sv */
`include "smrc_defs.vh"
module tb_smrc_servo_mode_ref;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys, sys_rst, parWrite, parRead, parAck, parReject;
  logic        pulseTrainA, pulseTrainB, velInWindow, motorStandstill;
  logic        selectedError, quickStop, errorStop, torqueRefNegative;
  logic        velocityModeActive, powerStageEnable, faultResetReq;
  logic        modeSwitchReq, velLimitReq, zeroClampReq, haltReq;
  logic [15:0] parAddr, parWdata, parRdata, analogInOne, analogInTwo;
  logic [15:0] torqueRefCurrent, analogOneTarget, analogTwoTarget, rv;
  logic [5:0]  digitalIn;
  logic [4:0]  digitalOut;
  logic [3:0]  driveState;
  logic [2:0]  analogOneUse, analogTwoUse;
  int          mismatches = 0;
  int          num_checks = 0;
  int          mdl [int];
  bit          en = 0;
  logic        ptRev = 1'b0;
  logic        ptSlow = 1'b0;
  int          adr [6] = '{'h091C, 'h0926, 'h2008, 'h3000, 'h3002, 'h3006};
  int          lim [6] = '{4, 5, 46300, 2, 1, 'h7FFF};

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  smrc_servo_mode_ref dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .parWrite(parWrite), .parRead(parRead), .parAddr(parAddr),
    .parWdata(parWdata), .parRdata(parRdata), .parAck(parAck),
    .parReject(parReject), .pulseTrainA(pulseTrainA),
    .pulseTrainB(pulseTrainB), .analogInOne(analogInOne),
    .analogInTwo(analogInTwo), .digitalIn(digitalIn),
    .driveState(driveState), .velInWindow(velInWindow),
    .motorStandstill(motorStandstill), .selectedError(selectedError),
    .quickStop(quickStop), .errorStop(errorStop), .digitalOut(digitalOut),
    .torqueRefCurrent(torqueRefCurrent),
    .torqueRefNegative(torqueRefNegative),
    .velocityModeActive(velocityModeActive),
    .powerStageEnable(powerStageEnable), .faultResetReq(faultResetReq),
    .modeSwitchReq(modeSwitchReq), .velLimitReq(velLimitReq),
    .zeroClampReq(zeroClampReq), .haltReq(haltReq),
    .analogOneUse(analogOneUse), .analogTwoUse(analogTwoUse),
    .analogOneTarget(analogOneTarget), .analogTwoTarget(analogTwoTarget));

  smrc_ctrl_model ctrl_u (.run(1'b1), .reverse(ptRev), .slow(ptSlow),
    .pulseTrainA(pulseTrainA), .pulseTrainB(pulseTrainB));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  function automatic bit rej(input int a, input int d);
    case (a)
      'h091C: return en || d > 4;
      'h0926: return en || d > 5;
      'h2008: return d > 46300;
      'h3000: return d > 2;
      'h3002: return d > 1;
      'h3004: return 0;
      'h3006: return d > 'h7FFF;
      default: return 1;
    endcase
  endfunction

  // Offset first, then the zero window, then clamp to the 16-bit range
  function automatic logic [15:0] anExp(input logic [15:0] r);
    int s;
    s = $signed(r) + $signed(16'(mdl['h3004]));
    if ((s < 0 ? -s : s) <= mdl['h3006]) return 16'h0000;
    if (s > 32'sh00007FFF) return 16'h7FFF;
    if (s < -32'sh00008000) return 16'h8000;
    return 16'(s);
  endfunction

  // Idle edge first, so no strobe is assigned twice in one step
  task automatic par(input logic wr, input logic [15:0] a, d);
    logic e;
    e = wr && rej(a, d);
    tick(1);
    {parWrite, parRead, parAddr, parWdata} = {wr, !wr, a, d};
    tick(1);
    {parWrite, parRead} = 2'b00;
    chk({parAck, parReject}, {!e, e});
    if (!wr) chk(parRdata, mdl.exists(a) ? mdl[a] : 0);
    else if (!e) mdl[a] = d;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {parWrite, parRead, parAddr, parWdata, analogInOne, analogInTwo} = '0;
    {digitalIn, driveState, velInWindow, motorStandstill} = '0;
    {selectedError, quickStop, errorStop} = '0;
    mdl = '{'h091C:1, 'h0926:0, 'h2008:0, 'h3000:2, 'h3002:0, 'h3004:0,
            'h3006:0};
    sys_rst = 1'b1;
    void'($urandom(32'hB2D1));
    repeat (6) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    foreach (mdl[a]) par(0, a, 16'h0000);
    par(0, 16'h1234, 16'h0000);
    $display("reset values done");
    foreach (adr[i]) begin
      par(1, adr[i], lim[i] + 1);
      par(1, adr[i], lim[i]);
      par(1, adr[i], $urandom_range(lim[i]));
      par(0, adr[i], 16'h0000);
    end
    for (int c = 0; c < 6; c++) par(1, 16'h0926, c);
    par(1, 16'h1234, 16'h0005);
    par(1, 16'h3000, 16'h0002);
    par(1, 16'h3006, 16'h0000);
    par(1, 16'h3004, 16'h0000);
    $display("bounds done");
    par(1, 16'h091C, 16'h0001);
    tick(4);
    chk(analogOneUse, 0);
    chk(analogTwoUse, 0);
    digitalIn = 6'h01;
    tick(4);
    en = 1;
    chk(analogOneUse, mdl['h091C]);
    chk(analogTwoUse, mdl['h0926]);
    chk(velocityModeActive, 1);
    par(1, 16'h091C, 16'h0002);
    par(0, 16'h091C, 16'h0000);
    $display("enable done");
    par(1, 16'h3004, $urandom_range(16'hFFFF));
    par(1, 16'h3006, $urandom_range(16'h0FFF));
    repeat (20) begin
      rv = $urandom;
      digitalIn = {1'b0, rv[4:1], 1'b1};
      driveState = rv[9:6];
      {velInWindow, motorStandstill, selectedError} = rv[12:10];
      {analogInOne, analogInTwo} = {rv, ~rv};
      tick(3);
      chk(digitalOut, {selectedError, motorStandstill, velInWindow,
        driveState == 4'h6, driveState inside {4'h4, 4'h5, 4'h6}});
      chk({haltReq, zeroClampReq, velLimitReq, modeSwitchReq,
        faultResetReq, powerStageEnable}, digitalIn);
      chk(analogOneTarget, anExp(analogInOne));
      chk(analogTwoTarget, anExp(analogInTwo));
    end
    $display("io done");
    {motorStandstill, quickStop} = 2'b01;
    tick(6);
    chk(velocityModeActive, 1);
    motorStandstill = 1'b1;
    tick(4);
    chk(velocityModeActive, 0);
    $display("stop done");
    par(1, 16'h3002, 16'h0000);
    par(1, 16'h3000, 16'h0001);
    digitalIn = 6'h19;
    velInWindow = 1'b1;
    tick(3);
    chk({zeroClampReq, velLimitReq, digitalOut[2]}, 3'h0);
    mdl['h3008] = {driveState, 12'h010};
    par(0, 16'h3008, 16'h0000);
    // First full count window closes about 100 us after reset
    tick(26000);
    rv = $urandom_range(46300);
    par(1, 16'h2008, rv);
    tick(2);
    chk(torqueRefCurrent, rv);
    chk(torqueRefNegative, 1'b0);
    par(1, 16'h3002, 16'h0001);
    tick(2);
    chk(torqueRefNegative, 1'b1);
    // Half rate backwards; one mixed window, then a clean one
    {ptRev, ptSlow} = 2'b11;
    tick(51000);
    chk(torqueRefCurrent, rv / 2);
    chk(torqueRefNegative, 1'b0);
    par(1, 16'h3000, 16'h0002);
    tick(2);
    chk(torqueRefCurrent, 16'h0000);
    $display("pulse done");
    end_of_test();
  end

  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end
endmodule
